// file: src/ext_bus_ctrl.sv
// External bus cycle engine with ready waits, mux waits and hold arbitration.
`timescale 1ns/1ps
// Function
// [R1] A ready input sampled high adds a wait state, sampled low ends the cycle.
// [R2] The responder may drop ready after the trailing edge of the command.
// [R3] Ready waits come on top of the programmed memory cycle wait states.
// [R4] The command leading edge is delayed by one step when r/w delay is set.
// [R5] Multiplexed cycles get a mux wait state, plus an optional tristate one.
// [R6] The gap is two bus clocks for mux with tristate, zero for plain demux.
// [R7] A hold request is granted only after the running cycle has finished.
// [R8] Once released, chip selects are no longer driven and rely on pull-ups.
// [R9] Regaining the bus starts only when the hold request goes inactive.
// [R10] Hold may be dropped at any time, with or without a regain request.
// [R11] While released, a pending access raises the regain request output.
module ext_bus_ctrl
  import ext_bus_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  link_clk,
  output logic                       bus_clock_output,
  output logic [EXT_ADDR_W-1:0]      addr_out,
  output logic                       addr_oe_n,
  output logic                       chip_select_outputs_n,
  output logic                       cs_oe_n,
  output logic                       rd_n_out,
  output logic                       wr_n_out,
  output logic                       ctrl_oe_n,
  output logic [EXT_DATA_W-1:0]      data_out,
  output logic                       data_oe_n,
  input  wire logic [EXT_DATA_W-1:0] data_in,
  input  wire logic                  ready_n_in,
  input  wire logic                  hold_request_n_in,
  output logic                       bus_hold_grant_out,
  output logic                       bus_regain_request_n_out
);

  typedef struct packed {
    logic [CTRL_W-1:0]     ctrl;
    logic [EXT_ADDR_W-1:0] addr;
    logic [EXT_DATA_W-1:0] wdata;
    logic                  dir_write;
    logic                  start_tog;
    logic                  ph_valid;
    logic                  ph_write;
    logic [7:0]            ph_addr;
    logic [31:0]           rdata;
  } host_state_t;

  typedef struct packed {
    bus_state_t            state;
    logic                  phase;
    logic [CTRL_WAIT_W-1:0] cnt;
    logic                  ack_tog;
    logic                  done_tog;
    logic                  rwd;
    logic                  mux;
    logic                  tri_en;
    logic                  write;
    logic [EXT_ADDR_W-1:0] addr;
    logic [EXT_DATA_W-1:0] wdata;
    logic [EXT_DATA_W-1:0] rdata;
    logic [RDY_CNT_W-1:0]  waits;
    logic                  cs_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  drive_n;
    logic                  data_oe_n;
    logic                  grant;
    logic                  bus_regain_request_out_n;
  } link_state_t;

  host_state_t h_q;
  host_state_t h_d;
  link_state_t l_q;
  link_state_t l_d;

  logic start_sync;
  logic done_sync;
  logic held_sync;
  logic ready_n_sync;
  logic hold_n_sync;
  logic busy;
  logic pending;
  logic tick;

  // Event crossings are toggles; their data is held still while busy.
  sync_cell #(.STAGES(3), .RESET_VAL(1'b0)) u_start (
    .clk   (link_clk),
    .rst_n (hresetn),
    .d     (h_q.start_tog),
    .q     (start_sync)
  );

  sync_cell #(.STAGES(3), .RESET_VAL(1'b0)) u_done (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (l_q.done_tog),
    .q     (done_sync)
  );

  sync_cell #(.STAGES(3), .RESET_VAL(1'b0)) u_held (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (l_q.grant),
    .q     (held_sync)
  );

  sync_cell #(.STAGES(3), .RESET_VAL(1'b1)) u_ready (
    .clk   (link_clk),
    .rst_n (hresetn),
    .d     (ready_n_in),
    .q     (ready_n_sync)
  );

  sync_cell #(.STAGES(3), .RESET_VAL(1'b1)) u_hold (
    .clk   (link_clk),
    .rst_n (hresetn),
    .d     (hold_request_n_in),
    .q     (hold_n_sync)
  );

  assign busy = h_q.start_tog != done_sync;

  // Zero-wait AHB-Lite slave; read data is fetched in the address phase.
  always_comb begin
    h_d          = h_q;
    h_d.ph_valid = hsel & htrans[1] & hready;
    if (h_d.ph_valid) begin
      h_d.ph_addr  = haddr[7:0];
      h_d.ph_write = hwrite;
      h_d.rdata    = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          OFS_CTRL:   h_d.rdata[CTRL_W-1:0] = h_q.ctrl;
          OFS_ADDR:   h_d.rdata[EXT_ADDR_W-1:0] = h_q.addr;
          OFS_WDATA:  h_d.rdata[EXT_DATA_W-1:0] = h_q.wdata;
          // Link-side words are shown only when idle, once they have settled.
          OFS_RDATA:  h_d.rdata[EXT_DATA_W-1:0] = busy ? '0 : l_q.rdata;
          OFS_STATUS: begin
            h_d.rdata[STAT_BUSY_BIT] = busy;
            h_d.rdata[STAT_HELD_BIT] = held_sync;
            h_d.rdata[STAT_WAIT_LSB +: RDY_CNT_W] = busy ? '0 : l_q.waits;
          end
          default:    h_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Writes while a cycle is in flight are dropped to keep crossed data still.
    if (h_q.ph_valid && h_q.ph_write && !busy) begin
      unique case (h_q.ph_addr)
        OFS_CTRL:  h_d.ctrl = hwdata[CTRL_W-1:0];
        OFS_ADDR:  h_d.addr = hwdata[EXT_ADDR_W-1:0];
        OFS_WDATA: h_d.wdata = hwdata[EXT_DATA_W-1:0];
        OFS_CMD: begin
          if (hwdata[CMD_START_BIT]) begin
            h_d.dir_write = hwdata[CMD_WRITE_BIT];
            h_d.start_tog = ~h_q.start_tog;
          end
        end
        default: h_d.ctrl = h_q.ctrl;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      h_q      <= '0;
      h_q.ctrl <= CTRL_RESET;
    end else begin
      h_q <= h_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = h_q.rdata;

  assign pending = start_sync != l_q.ack_tog;
  assign tick    = l_q.phase;

  // The engine steps once per bus clock period, at its falling half.
  always_comb begin
    l_d       = l_q;
    l_d.phase = ~l_q.phase;
    if (tick) begin
      unique case (l_q.state)
        S_IDLE: begin
          if (!hold_n_sync) begin
            l_d.state   = S_RELEASED; // see [R7]
            l_d.grant   = 1'b1;
            l_d.drive_n = 1'b1; // see [R8]
            l_d.bus_regain_request_out_n  = pending ? 1'b0 : 1'b1; // see [R11]
          end else if (pending) begin
            l_d.state   = S_ADDR;
            l_d.ack_tog = start_sync;
            l_d.cnt     = h_q.ctrl[CTRL_WAIT_LSB +: CTRL_WAIT_W];
            l_d.rwd     = h_q.ctrl[CTRL_RWD_BIT];
            l_d.mux     = h_q.ctrl[CTRL_MUX_BIT];
            l_d.tri_en  = h_q.ctrl[CTRL_TRI_BIT];
            l_d.write   = h_q.dir_write;
            l_d.addr    = h_q.addr;
            l_d.wdata   = h_q.wdata;
            l_d.waits   = '0;
            l_d.cs_n    = 1'b0;
          end
        end
        S_ADDR: begin
          l_d.data_oe_n = ~l_q.write;
          if (l_q.rwd) begin
            l_d.state = S_DELAY; // see [R4]
          end else begin
            l_d.state = S_CMD;
            l_d.rd_n  = l_q.write;
            l_d.wr_n  = ~l_q.write;
          end
        end
        S_DELAY: begin
          l_d.state = S_CMD; // see [R4]
          l_d.rd_n  = l_q.write;
          l_d.wr_n  = ~l_q.write;
        end
        S_CMD: begin
          // Programmed wait states run first, ready waits only after them.
          if (l_q.cnt == '0) begin
            l_d.state = S_SAMPLE; // see [R3]
          end else begin
            l_d.cnt = l_q.cnt - 1'b1;
          end
        end
        S_SAMPLE: begin
          if (ready_n_sync) begin
            l_d.waits = l_q.waits + 1'b1; // see [R1] [R3]
          end else begin
            // The trailing command edge here lets the responder drop ready.
            l_d.rdata     = l_q.write ? l_q.rdata : data_in; // see [R1]
            l_d.rd_n      = 1'b1; // see [R2]
            l_d.wr_n      = 1'b1;
            l_d.cs_n      = 1'b1;
            l_d.data_oe_n = 1'b1;
            l_d.done_tog  = ~l_q.done_tog;
            if (l_q.mux) begin
              l_d.state = S_MUXW; // see [R5]
            end else if (l_q.tri_en) begin
              l_d.state = S_TRIW;
            end else begin
              l_d.state = S_IDLE; // see [R6]
            end
          end
        end
        S_MUXW: begin
          l_d.state = l_q.tri_en ? S_TRIW : S_IDLE; // see [R5] [R6]
        end
        S_TRIW: begin
          l_d.state = S_IDLE; // see [R6]
        end
        S_RELEASED: begin
          // A regain request alone never takes the bus back.
          l_d.bus_regain_request_out_n = pending ? 1'b0 : 1'b1; // see [R11]
          if (hold_n_sync) begin
            l_d.state  = S_REGAIN; // see [R9] [R10]
            l_d.bus_regain_request_out_n = 1'b1;
          end
        end
        S_REGAIN: begin
          l_d.state   = S_IDLE; // see [R9]
          l_d.grant   = 1'b0;
          l_d.drive_n = 1'b0;
        end
        default: l_d.state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      l_q           <= '0;
      l_q.state     <= S_IDLE;
      l_q.cs_n      <= 1'b1;
      l_q.rd_n      <= 1'b1;
      l_q.wr_n      <= 1'b1;
      l_q.data_oe_n <= 1'b1;
      l_q.bus_regain_request_out_n    <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  assign bus_clock_output         = l_q.phase;
  assign addr_out                 = l_q.addr;
  assign addr_oe_n                = l_q.drive_n;
  assign chip_select_outputs_n    = l_q.cs_n;
  assign cs_oe_n                  = l_q.drive_n; // see [R8]
  assign rd_n_out                 = l_q.rd_n;
  assign wr_n_out                 = l_q.wr_n;
  assign ctrl_oe_n                = l_q.drive_n;
  assign data_out                 = l_q.wdata;
  assign data_oe_n                = l_q.data_oe_n | l_q.drive_n;
  assign bus_hold_grant_out       = l_q.grant;
  assign bus_regain_request_n_out = l_q.bus_regain_request_out_n;

endmodule : ext_bus_ctrl

// file: src/ext_bus_pkg.sv
// Shared constants and types for the external bus cycle and hold controller.
package ext_bus_pkg;

  // Register byte offsets on the AHB-Lite side.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_WDATA  = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields.
  localparam int CTRL_WAIT_LSB = 0;
  localparam int CTRL_WAIT_W   = 4;
  localparam int CTRL_RWD_BIT  = 4;
  localparam int CTRL_MUX_BIT  = 5;
  localparam int CTRL_TRI_BIT  = 6;
  localparam int CTRL_W        = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Command register fields.
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_START_BIT = 1;

  // Status register fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HELD_BIT = 1;
  localparam int STAT_WAIT_LSB = 8;

  // Widths of the external bus and of the ready wait counter.
  localparam int EXT_ADDR_W = 24;
  localparam int EXT_DATA_W = 16;
  localparam int RDY_CNT_W  = 8;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_DELAY,
    S_CMD,
    S_SAMPLE,
    S_MUXW,
    S_TRIW,
    S_RELEASED,
    S_REGAIN
  } bus_state_t;

endpackage : ext_bus_pkg

// file: src/sync_cell.sv
// Three-stage synchroniser with an agreement filter on the last two stages.
`timescale 1ns/1ps
module sync_cell
  import ext_bus_pkg::*;
#(
  parameter int   STAGES    = 3,
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic [STAGES-1:0] sr;
    logic              q;
  } sync_state_t;

  sync_state_t r_q;
  sync_state_t r_d;

  // The first stage feeds only the second; the filter sees the later ones.
  always_comb begin
    r_d    = r_q;
    r_d.sr = {r_q.sr[STAGES-2:0], d};
    if (r_q.sr[STAGES-1] == r_q.sr[STAGES-2]) begin
      r_d.q = r_q.sr[STAGES-1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{sr: {STAGES{RESET_VAL}}, q: RESET_VAL};
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.q;

endmodule : sync_cell

// file: tb/ext_bus_ctrl_chk.sv
// Port assertions for the external bus controller.
`timescale 1ns/1ps
module ext_bus_ctrl_chk (
  input wire logic hresetn,
  input wire logic link_clk,
  input wire logic chip_select_outputs_n,
  input wire logic cs_oe_n,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic ready_n_in,
  input wire logic hold_request_n_in,
  input wire logic bus_hold_grant_out,
  input wire logic bus_regain_request_n_out,
  input wire logic addr_oe_n,
  input wire logic ctrl_oe_n,
  input wire logic data_oe_n,
  input wire logic bus_clock_output
);
  default clocking dc @(posedge link_clk);
  endclocking
  default disable iff (!hresetn);
  wire cs_on = !chip_select_outputs_n && !cs_oe_n;
  chk_ready_wait: assert property (
    ready_n_in [*8] ##0 cs_on |=> cs_on) else $error("ended on ready high");
  chk_cmd_in_cs: assert property (
    !cs_oe_n && !(rd_n_out && wr_n_out) |-> cs_on) else $error("cmd out of cs");
  chk_one_cmd: assert property (
    !cs_oe_n |-> rd_n_out || wr_n_out) else $error("both commands low");
  chk_grant_idle: assert property (
    $rose(bus_hold_grant_out) |-> !$past(cs_on)) else $error("grant in cycle");
  chk_cs_float: assert property (
    bus_hold_grant_out |-> cs_oe_n) else $error("cs driven when released");
  chk_pins_float: assert property (
    bus_hold_grant_out |-> addr_oe_n && ctrl_oe_n && data_oe_n)
    else $error("pins driven when released");
  chk_hold_keeps: assert property (
    (!hold_request_n_in) [*8] ##0 bus_hold_grant_out |=> bus_hold_grant_out)
    else $error("bus taken back under hold");
  chk_drop_regain: assert property (
    $rose(hold_request_n_in) && bus_hold_grant_out |-> ##[1:16]
    !bus_hold_grant_out) else $error("bus not taken back");
  chk_bus_regain_request_out_held: assert property (
    !bus_regain_request_n_out |-> bus_hold_grant_out) else $error("stray bus_regain_request_out");
  chk_regain_drive: assert property (
    $fell(bus_hold_grant_out) |-> !cs_oe_n) else $error("cs not driven");
  // The gaps are counted in bus clock periods, so that clock must keep running.
  chk_clk_runs: assert property (
    $past(hresetn) |-> bus_clock_output != $past(bus_clock_output))
    else $error("bus clock stopped");
  cover property (bus_hold_grant_out && !bus_regain_request_n_out);
  cover property (cs_on && ready_n_in && !rd_n_out);
  cover property ($fell(bus_hold_grant_out));
endmodule : ext_bus_ctrl_chk

bind ext_bus_ctrl ext_bus_ctrl_chk ext_bus_ctrl_chk_inst (.hresetn,
  .link_clk, .chip_select_outputs_n, .cs_oe_n, .rd_n_out, .wr_n_out,
  .ready_n_in, .hold_request_n_in, .bus_hold_grant_out,
  .bus_regain_request_n_out, .addr_oe_n, .ctrl_oe_n, .data_oe_n,
  .bus_clock_output);

// file: tb/ext_bus_ctrl_tb.sv
// Random and directed bench for the external bus controller.
`timescale 1ns/1ps
module ext_bus_ctrl_tb
  import ext_bus_pkg::*;
;
  logic        hclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        hold_n = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [4:0]  lat = 5'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic        hreadyout, hresp, cs_n, cs_oe, ctl_oe, rd_n, wr_n, rdy_n;
  logic        grant, bus_regain_request_out_n;
  logic [23:0] ao;
  logic [15:0] dout, din;
  int          n_errors = 0, n_tests = 0, cs_len, pre_len;
  int          cs_base = 0, pre_base = 0;
  always #50 hclk = ~hclk;
  always #7.5 link_clk = ~link_clk;
  ext_bus_ctrl ext_bus_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .link_clk, .bus_clock_output(), .addr_out(ao), .addr_oe_n(),
    .chip_select_outputs_n(cs_n), .cs_oe_n(cs_oe), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .ctrl_oe_n(ctl_oe), .data_out(dout), .data_oe_n(),
    .data_in(din), .ready_n_in(rdy_n), .hold_request_n_in(hold_n),
    .bus_hold_grant_out(grant), .bus_regain_request_n_out(bus_regain_request_out_n));
  // Released chip select and command lines are pulled up, so the memory sees them high.
  ext_mem_model ext_mem_model_inst (.link_clk, .lat, .addr(ao[3:0]),
    .cs_n(cs_n | cs_oe), .rd_n(rd_n | ctl_oe), .wr_n(wr_n | ctl_oe),
    .wdata(dout), .ready_n(rdy_n), .rdata(din));
  always @(posedge link_clk)
    if (!cs_n && !cs_oe) begin
      cs_len <= cs_len + 1;
      if (rd_n && wr_n) pre_len <= pre_len + 1;
    end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic to_fail();
    n_errors++;
    finish_test();
  endtask : to_fail
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic hwait();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) to_fail();
  endtask : hwait
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rdv = hrdata;
  endtask : ahb
  task automatic wait_for(ref logic s, input logic v);
    int i;
    for (i = 0; i < 400 && s !== v; i++) @(posedge hclk);
    if (s !== v) to_fail();
  endtask : wait_for
  task automatic start(logic w, logic [23:0] a, logic [15:0] d);
    ahb(1'b1, OFS_ADDR, {8'h0, a});
    ahb(1'b1, OFS_WDATA, {16'h0, d});
    cs_base = cs_len;
    pre_base = pre_len;
    ahb(1'b1, OFS_CMD, {30'h0, 1'b1, w});
  endtask : start
  task automatic idle();
    int i;
    for (i = 0; i < 100; i++) begin
      ahb(1'b0, OFS_STATUS, 32'h0);
      if (rdv[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 100) to_fail();
  endtask : idle
  function automatic int min_len(logic [6:0] c, logic [4:0] l);
    int p;
    p = 2 + 2 * c[CTRL_RWD_BIT];
    return (p + 2 * c[3:0] + 4 > p + l + 3) ? p + 2 * c[3:0] + 4 : p + l + 3;
  endfunction : min_len
  initial begin
    logic [6:0]  cfg;
    logic [23:0] a;
    logic [15:0] d;
    void'($urandom(32'h0C3C4D3C));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", {25'h0, CTRL_RESET}, rdv);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, rdv);
    chk("hresp", 32'h0, {31'h0, hresp});
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rdv);
    for (int k = 0; k < 10; k++) begin
      cfg = k == 0 ? 7'h00 : k == 1 ? 7'h7F : 7'($urandom);
      lat <= k == 1 ? 5'h1F : 5'($urandom_range(12));
      a = 24'($urandom);
      d = 16'($urandom);
      ahb(1'b1, OFS_CTRL, {25'h0, cfg});
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", {25'h0, cfg}, rdv);
      start(1'b1, a, d);
      idle();
      start(1'b0, a, ~d);
      idle();
      ahb(1'b0, OFS_RDATA, 32'h0);
      chk("rdata", {16'h0, d}, rdv);
      chk("cycle len", 1, cs_len - cs_base >= min_len(cfg, lat));
      chk("lead", 2 + 2 * cfg[4], pre_len - pre_base);
    end
    lat <= 5'h1F;
    start(1'b0, a, ~d);
    for (int i = 0; i < 200 && cs_n !== 1'b0; i++) @(posedge link_clk);
    if (cs_n !== 1'b0) to_fail();
    @(posedge hclk);
    hold_n <= 1'b0;
    wait_for(grant, 1'b1);
    chk("cs float", 1, cs_oe);
    // Busy and held come back through synchronisers, a few cycles late.
    repeat (4) @(posedge hclk);
    ahb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata at grant", {16'h0, d}, rdv);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("held", 2'h2, rdv[1:0]);
    start(1'b1, a, ~d);
    wait_for(bus_regain_request_out_n, 1'b0);
    chk("grant kept", 1, grant);
    hold_n <= 1'b1;
    wait_for(grant, 1'b0);
    chk("cs driven", 0, cs_oe);
    idle();
    start(1'b0, a, d);
    idle();
    ahb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata regained", {16'h0, ~d}, rdv);
    hold_n <= 1'b0;
    wait_for(grant, 1'b1);
    chk("no request", 1, bus_regain_request_out_n);
    hold_n <= 1'b1;
    wait_for(grant, 1'b0);
    repeat (4) @(posedge hclk);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("released", 2'h0, rdv[1:0]);
    finish_test();
  end
endmodule : ext_bus_ctrl_tb

// file: tb/ext_mem_model.sv
// Behavioural external memory answering with a programmable ready delay.
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        link_clk,
  input  wire logic [4:0]  lat,
  input  wire logic [3:0]  addr,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] wdata,
  output logic             ready_n,
  output logic [15:0]      rdata
);
  logic [15:0] mem [16];
  logic [5:0]  cnt = 6'h00;
  wire         cmd = !cs_n && !(rd_n && wr_n);
  initial ready_n = 1'b1;
  initial rdata = 16'h0000;
  always @(posedge link_clk) begin
    cnt <= cmd ? cnt + 6'h01 : 6'h00;
    // Ready is dropped with the command so it cannot leak into the next.
    ready_n <= !(cmd && cnt >= {1'b0, lat});
    if (!wr_n && !cs_n) mem[addr] <= wdata;
    // Released data lines wander instead of keeping the last value.
    rdata <= (!rd_n && !cs_n) ? mem[addr] : ~rdata;
  end
endmodule : ext_mem_model
